// ### shared/codec_port_params.svh
// Purpose: constants of the codec control port, shared by both ends
// Assumes: 100 MHz i_ref_clk on both ends
// Notes:   times are in ns, cycle counts derive from them
`ifndef CODEC_PORT_PARAMS_SVH
`define CODEC_PORT_PARAMS_SVH

`define CLK_MHZ        100
`define ADDR_PREFIX    5'h06
`define DIR_WRITE      1'b0
`define DIR_READ       1'b1
`define SPI_HALF_NS    100
`define SPI_HALF_CYC   ((`SPI_HALF_NS * `CLK_MHZ + 999) / 1000)
`define I2C_QTR_NS     250
`define I2C_QTR_CYC    ((`I2C_QTR_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### shared/codec_port_pkg.sv
// Purpose: types of the codec control port
// Assumes: constants come from codec_port_params.svh
// Notes:   all module state lives in one packed struct per end
package codec_port_pkg;

    // Two-wire slave progress
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WDATA, I_READ, I_SKIP} i2c_phase_t;
    // Four-wire slave progress
    typedef enum logic [1:0] {S_CMD, S_DATA, S_DONE} spi_phase_t;
    // Host sequencer
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_SPI} host_state_t;

    // Device state
    typedef struct packed {
        logic [127:0][7:0] mem;
        logic [1:0]  scl_r;
        logic [1:0]  sda_r;
        logic [1:0]  sclk_r;
        logic [1:0]  stl_m;
        logic [1:0]  stl_s;
        logic        scl_p;
        logic        sda_p;
        logic        sclk_p;
        i2c_phase_t  ph;
        logic [3:0]  cnt;
        logic [7:0]  rx;
        logic [7:0]  tx;
        logic [6:0]  ptr;
        logic        sda_oe;
        spi_phase_t  sp;
        logic [2:0]  scnt;
        logic        rw;
        logic [7:0]  so;
        logic        miso;
        logic        miso_oe;
        logic        wr_valid;
        logic [6:0]  wr_addr;
        logic [7:0]  wr_data;
    } dev_state_t;

    // Host state
    typedef struct packed {
        host_state_t st;
        logic [4:0]  div;
        logic [1:0]  q;
        logic [3:0]  bitn;
        logic [1:0]  bidx;
        logic [7:0]  sh;
        logic [15:0] sh16;
        logic [5:0]  ecnt;
        logic [1:0]  sda_r;
        logic [1:0]  miso_r;
        logic        write;
        logic        spi;
        logic [1:0]  sel;
        logic [6:0]  addr;
        logic [7:0]  wdata;
        logic        scl_o;
        logic        scl_oe;
        logic        sda_o;
        logic        sda_oe;
        logic        sclk;
        logic [7:0]  rdata;
        logic        busy;
        logic        done;
        logic        nack;
    } host_state_s_t;

endpackage : codec_port_pkg

// ### shared/codec_link_if.sv
// Purpose: pins between host and codec control port
// Assumes: open-drain lines are pulled high when nobody pulls low
// Notes:   the wire levels are resolved here from the enables
`timescale 1ns/100ps
interface codec_link_if;
    logic h_scl_o;     // Host clock / select value
    logic h_scl_oe;    // Host drives clock / select
    logic h_sda_o;     // Host data / MOSI value
    logic h_sda_oe;    // Host drives data / MOSI
    logic h_sclk;      // Four-wire serial clock
    logic d_sda_o;     // Device data value, always low
    logic d_sda_oe;    // Device pulls data low
    logic d_miso;      // Device MISO value
    logic d_miso_oe;   // Device drives MISO
    logic scl;         // Resolved clock / select
    logic sda;         // Resolved data / MOSI
    logic sclk;        // Serial clock wire
    logic miso;        // Resolved MISO, pulled high when idle

    // Wired-AND with pull-up
    assign scl  = !(h_scl_oe && !h_scl_o);
    assign sda  = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);
    assign sclk = h_sclk;
    assign miso = d_miso_oe ? d_miso : 1'b1;

    modport device (input scl, sda, sclk, output d_sda_o, d_sda_oe, d_miso, d_miso_oe);
    modport host (input sda, miso, output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, h_sclk);
endinterface : codec_link_if

// ### rtl/codec_port_device.sv
// Purpose: codec control port slave, two-wire or four-wire
// Assumes: i_spi_mode is static while a frame runs
// Notes:   holds 128 byte registers; writes are also reported out
`timescale 1ns/100ps
`include "codec_port_params.svh"
module codec_port_device import codec_port_pkg::*; (
    // Clock, reset, enable
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    // Mode and address straps
    input  wire logic         i_spi_mode,
    input  wire logic         i_addr_strap_low_pin,
    input  wire logic         i_addr_strap_high_pin,
    // Link pins
    codec_link_if.device      link,
    // Register write report
    output logic              o_wr_valid,
    output logic [6:0]        o_wr_addr,
    output logic [7:0]        o_wr_data
);

    dev_state_t q;            // Registered state
    dev_state_t d;            // Next state

    // Two-wire slave address from the straps
    function automatic logic addr_match(input logic [7:0] b, input logic [1:0] s);
        addr_match = (b[7:1] == {`ADDR_PREFIX, s[1], s[0]});
    endfunction : addr_match

    // Helpers from synchronised pins
    logic scl_s;              // Clock, or select in four-wire mode
    logic sda_s;              // Data, or MOSI in four-wire mode
    logic sclk_s;             // Four-wire serial clock
    logic start_c;            // Two-wire start or repeated start
    logic stop_c;             // Two-wire stop
    logic rise_c;             // Two-wire clock rise
    logic fall_c;             // Two-wire clock fall
    logic srise_c;            // Serial clock rise
    logic sfall_c;            // Serial clock fall
    logic [7:0] nrx;          // Received byte with new bit, either mode

    assign scl_s   = q.scl_r[1];
    assign sda_s   = q.sda_r[1];
    assign sclk_s  = q.sclk_r[1];
    assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
    assign stop_c  = scl_s && q.scl_p && !q.sda_p && sda_s;
    assign rise_c  = scl_s && !q.scl_p;
    assign fall_c  = !scl_s && q.scl_p;
    assign srise_c = sclk_s && !q.sclk_p;
    assign sfall_c = !sclk_s && q.sclk_p;
    assign nrx     = {q.rx[6:0], sda_s};

    // Next state
    always_comb begin
        d = q;
        if (i_ce) begin
            // Synchronisers; only stage 1 reads stage 0
            d.scl_r  = {q.scl_r[0], link.scl};
            d.sda_r  = {q.sda_r[0], link.sda};
            d.sclk_r = {q.sclk_r[0], link.sclk};
            d.stl_m  = {i_addr_strap_high_pin, i_addr_strap_low_pin};
            d.stl_s  = q.stl_m;
            d.scl_p  = scl_s;
            d.sda_p  = sda_s;
            d.sclk_p = sclk_s;
            d.wr_valid = 1'b0;

            if (!i_spi_mode) begin
                // Two-wire slave; four-wire side held quiet
                d.sp      = S_CMD;
                d.scnt    = 3'h0;
                d.miso_oe = 1'b0;
                if (start_c) begin
                    // Start or repeated start opens an address byte
                    d.ph     = I_ADDR;
                    // Parked past the acknowledge: the start's own clock fall
                    // only rewinds to bit 0, it is not counted as a data bit
                    d.cnt    = 4'h8;
                    d.sda_oe = 1'b0;
                end else if (stop_c) begin
                    d.ph     = I_IDLE;
                    d.sda_oe = 1'b0;
                end else if (q.ph != I_IDLE) begin
                    if (rise_c) begin
                        if (q.cnt < 4'h8) begin
                            d.rx = nrx;
                        end else if (q.ph == I_READ && sda_s) begin
                            // Host declined more data
                            d.ph = I_SKIP;
                        end
                    end
                    if (fall_c) begin
                        // Only ever pull low or let go
                        d.sda_oe = 1'b0;
                        if (q.cnt == 4'h7) begin
                            d.cnt = 4'h8;
                            case (q.ph)
                                I_ADDR: begin
                                    if (addr_match(q.rx, q.stl_s)) begin
                                        d.sda_oe = 1'b1;
                                        d.ph = (q.rx[0] == `DIR_READ) ? I_READ : I_REG;
                                    end else begin
                                        d.ph = I_SKIP;
                                    end
                                end
                                I_REG: begin
                                    // Register byte sets the pointer
                                    d.ptr    = q.rx[6:0];
                                    d.sda_oe = 1'b1;
                                    d.ph     = I_WDATA;
                                end
                                I_WDATA: begin
                                    // Store, acknowledge, step pointer
                                    d.mem[q.ptr] = q.rx;
                                    d.wr_valid   = 1'b1;
                                    d.wr_addr    = q.ptr;
                                    d.wr_data    = q.rx;
                                    d.sda_oe     = 1'b1;
                                    d.ptr        = q.ptr + 7'h01;
                                end
                                I_READ: begin
                                    // Release for host acknowledge
                                    d.ptr = q.ptr + 7'h01;
                                end
                                default: begin
                                    d.ph = q.ph;
                                end
                            endcase
                        end else begin
                            d.cnt = (q.cnt == 4'h8) ? 4'h0 : q.cnt + 4'h1;
                            if (q.ph == I_READ) begin
                                // Return data, pulling low for zeros
                                d.tx     = (q.cnt == 4'h8) ? q.mem[q.ptr] : {q.tx[6:0], 1'b0};
                                d.sda_oe = !d.tx[7];
                            end
                        end
                    end
                end
            end else begin
                // Four-wire slave: clock pin is select, data pin is MOSI
                d.ph     = I_IDLE;
                d.sda_oe = 1'b0;
                if (scl_s) begin
                    // Select high drops any partial frame
                    d.sp      = S_CMD;
                    d.scnt    = 3'h0;
                    d.so      = 8'h00;
                    d.miso_oe = 1'b0;
                end else if (q.sp != S_DONE) begin
                    if (srise_c) begin
                        // Launch next bit; first edge starts driving
                        d.miso_oe = 1'b1;
                        d.miso    = q.so[7];
                        d.so      = {q.so[6:0], 1'b0};
                    end
                    if (sfall_c) begin
                        // Capture MOSI on the falling edge
                        d.rx   = nrx;
                        d.scnt = q.scnt + 3'h1;
                        if (q.scnt == 3'h7) begin
                            if (q.sp == S_CMD) begin
                                // Command: address then direction
                                d.ptr = nrx[7:1];
                                d.rw  = nrx[0];
                                d.so  = (nrx[0] == `DIR_READ) ? q.mem[nrx[7:1]] : 8'h00;
                                d.sp  = S_DATA;
                            end else begin
                                if (q.rw == `DIR_WRITE) begin
                                    d.mem[q.ptr] = nrx;
                                    d.wr_valid   = 1'b1;
                                    d.wr_addr    = q.ptr;
                                    d.wr_data    = nrx;
                                end
                                // Later bits until select rises are ignored
                                d.sp = S_DONE;
                            end
                        end
                    end
                end
            end
        end
    end

    // State register; reset puts every field at a constant
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q        <= '0;
            q.scl_r  <= 2'h3;
            q.sda_r  <= 2'h3;
            q.scl_p  <= 1'b1;
            q.sda_p  <= 1'b1;
            q.ph     <= I_IDLE;
            q.sp     <= S_CMD;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register, except the data value, which is tied low
    assign link.d_sda_o    = 1'b0;
    assign link.d_sda_oe   = q.sda_oe;
    assign link.d_miso     = q.miso;
    assign link.d_miso_oe  = q.miso_oe;
    assign o_wr_valid      = q.wr_valid;
    assign o_wr_addr       = q.wr_addr;
    assign o_wr_data       = q.wr_data;

endmodule : codec_port_device

// ### rtl/codec_port_host.sv
// Purpose: host master for the codec control port
// Assumes: one request at a time, taken only while not busy
// Notes:   two-wire reads take one byte then decline more
`timescale 1ns/100ps
`include "codec_port_params.svh"
module codec_port_host import codec_port_pkg::*; (
    // Clock, reset, enable
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    // Request
    input  wire logic         i_start,
    input  wire logic         i_spi,
    input  wire logic         i_write,
    input  wire logic [1:0]   i_dev_sel,
    input  wire logic [6:0]   i_addr,
    input  wire logic [7:0]   i_wdata,
    // Answer
    output logic              o_busy,
    output logic              o_done,
    output logic              o_nack,
    output logic [7:0]        o_rdata,
    // Link pins
    codec_link_if.host        link
);

    host_state_s_t q;         // Registered state
    host_state_s_t d;         // Next state
    logic          tick;      // Quarter or half period elapsed

    // Byte sent at each two-wire step
    function automatic logic [7:0] tx_byte(input host_state_s_t s, input logic [1:0] i);
        case (i)
            2'h0:    tx_byte = {`ADDR_PREFIX, s.sel, `DIR_WRITE};
            2'h1:    tx_byte = {1'b0, s.addr};
            2'h2:    tx_byte = s.write ? s.wdata : {`ADDR_PREFIX, s.sel, `DIR_READ};
            default: tx_byte = 8'hFF;                             // Released for read
        endcase
    endfunction : tx_byte

    assign tick = q.div == (q.spi ? 5'(`SPI_HALF_CYC - 1) : 5'(`I2C_QTR_CYC - 1));

    // Next state
    always_comb begin
        d = q;
        if (i_ce) begin
            d.sda_r  = {q.sda_r[0], link.sda};
            d.miso_r = {q.miso_r[0], link.miso};
            d.done   = 1'b0;
            d.div    = (tick || q.st == H_IDLE) ? 5'h0 : q.div + 5'h1;
            case (q.st)
                H_IDLE: begin
                    // Idle: select high in four-wire, lines released otherwise
                    d.scl_o  = 1'b1;
                    d.scl_oe = q.spi;
                    d.sda_oe = 1'b0;
                    d.sclk   = 1'b0;
                    if (i_start) begin
                        // Host alone opens a transfer
                        d.busy  = 1'b1;
                        d.nack  = 1'b0;
                        d.spi   = i_spi;
                        d.write = i_write;
                        d.sel   = i_dev_sel;
                        d.addr  = i_addr;
                        d.wdata = i_wdata;
                        d.bidx  = 2'h0;
                        d.q     = 2'h0;
                        d.ecnt  = 6'h0;
                        d.sh16  = {i_addr, !i_write, i_write ? i_wdata : 8'h00};
                        d.st    = i_spi ? H_SPI : H_START;
                        d.scl_o = !i_spi;  // Select falls
                        d.scl_oe = i_spi;
                    end
                end
                H_SPI: begin
                    if (tick) begin
                        d.ecnt = q.ecnt + 6'h1;
                        if (q.ecnt == 6'h20) begin
                            // Raise select after sixteen clocks
                            d.scl_o  = 1'b1;
                            d.sda_oe = 1'b0;
                            d.rdata  = q.sh16[7:0];
                            d.busy   = 1'b0;
                            d.done   = 1'b1;
                            d.st     = H_IDLE;
                        end else if (!q.ecnt[0]) begin
                            // Rise: launch MSB first from the first edge
                            d.sclk   = 1'b1;
                            d.sda_o  = q.sh16[15];
                            d.sda_oe = 1'b1;
                        end else begin
                            // Fall: sample MISO, shift
                            d.sclk = 1'b0;
                            d.sh16 = {q.sh16[14:0], q.miso_r[1]};
                        end
                    end
                end
                H_START: begin
                    // Start, or repeated start before the read address
                    if (tick) begin
                        d.q = q.q + 2'h1;
                        case (q.q)
                            2'h0:    d.sda_oe = 1'b0;
                            2'h1:    d.scl_oe = 1'b0;
                            2'h2:    d.sda_oe = 1'b1;
                            default: begin
                                d.scl_oe = 1'b1;
                                d.bitn   = 4'h0;
                                d.sh     = tx_byte(q, q.bidx);
                                d.st     = H_BIT;
                            end
                        endcase
                        d.sda_o = 1'b0;
                        d.scl_o = 1'b0;
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        d.q = q.q + 2'h1;
                        case (q.q)
                            2'h0:    d.sda_oe = (q.bitn < 4'h8) && !q.sh[7];
                            2'h1:    d.scl_oe = 1'b0;
                            2'h2: begin
                                if (q.bitn < 4'h8) begin
                                    d.sh = {q.sh[6:0], q.sda_r[1]};
                                end else if (q.bidx != 2'h3 && q.sda_r[1]) begin
                                    d.nack = 1'b1;
                                end
                            end
                            default: begin
                                d.scl_oe = 1'b1;
                                d.bitn   = q.bitn + 4'h1;
                                if (q.bitn == 4'h8) begin
                                    d.bitn = 4'h0;
                                    d.bidx = q.bidx + 2'h1;
                                    d.sh   = tx_byte(q, q.bidx + 2'h1);
                                    if (q.nack || (q.write && q.bidx == 2'h2)) begin
                                        d.st = H_STOP;
                                    end else if (q.bidx == 2'h3) begin
                                        d.rdata = q.sh;
                                        d.st    = H_STOP;
                                    end else if (!q.write && q.bidx == 2'h1) begin
                                        d.st = H_START;
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    // Stop condition, then report
                    if (tick) begin
                        d.q = q.q + 2'h1;
                        case (q.q)
                            2'h0:    d.sda_oe = 1'b1;
                            2'h1:    d.scl_oe = 1'b0;
                            2'h2:    d.sda_oe = 1'b0;
                            default: begin
                                d.busy = 1'b0;
                                d.done = 1'b1;
                                d.st   = H_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q        <= '0;
            q.st     <= H_IDLE;
            q.scl_o  <= 1'b1;
            q.sda_r  <= 2'h3;
            q.miso_r <= 2'h3;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign link.h_scl_o  = q.scl_o;
    assign link.h_scl_oe = q.scl_oe;
    assign link.h_sda_o  = q.sda_o;
    assign link.h_sda_oe = q.sda_oe;
    assign link.h_sclk   = q.sclk;
    assign o_busy        = q.busy;
    assign o_done        = q.done;
    assign o_nack        = q.nack;
    assign o_rdata       = q.rdata;

endmodule : codec_port_host

// ### verif/codec_link_sva.sv
// Purpose: checks on the link wires between host and device
// Assumes: both ends run on i_ref_clk
// Notes:   edges_q counts clock rises; nonzero marks a four-wire frame
`timescale 1ns/100ps
module codec_link_sva (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Link signals
    input wire logic h_sda_oe,
    input wire logic h_sclk,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic d_miso,
    input wire logic d_miso_oe,
    input wire logic scl,
    input wire logic sclk
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [4:0] edges_q; // Clock rises in this frame
    // Count rises while select is low
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || scl) edges_q <= 5'h00;
        else if ($rose(sclk)) edges_q <= edges_q + 5'h01;
    end
    low_only_a: assert property (!d_sda_o) else $error("device drove data high");
    clk_idle_a: assert property (h_sclk |-> !scl) else $error("clock outside select");
    frame_len_a: assert property ($rose(scl) && edges_q != 5'h00 |-> edges_q == 5'h10)
        else $error("frame not sixteen clocks");
    miso_rel_a: assert property ($rose(scl) && edges_q != 5'h00 |-> ##[1:5] !d_miso_oe)
        else $error("miso held after select");
    mosi_rel_a: assert property ($rose(scl) && edges_q != 5'h00 |-> !h_sda_oe)
        else $error("mosi held after select");
    miso_start_a: assert property ($rose(d_miso_oe) |-> !scl && sclk)
        else $error("miso began off a rise");
    miso_edge_a: assert property ($changed(d_miso) && d_miso_oe && $past(d_miso_oe)
        |-> sclk && $past(sclk, 2)) else $error("miso moved off a rise");
    ack_edge_a: assert property ($changed(d_sda_oe) |-> !scl && !$past(scl, 2))
        else $error("data moved while clock high");
endmodule : codec_link_sva

// ### verif/codec_control_port_bench.sv
// Purpose: host against device over the link, self-checking
// Assumes: straps and mode settle before each request
// Notes:   mirror predicts read data; device never aborts mid-frame here
`timescale 1ns/100ps
module codec_control_port_bench;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, start = 1'b0, spi = 1'b0, wr = 1'b0;
    logic [1:0] sel = 2'h0, strap = 2'h0;        // Request target, strap pins
    logic [6:0] addr = 7'h00, wr_addr, got_a;   // Register address, write report
    logic [7:0] wdata = 8'h00, rdata, wr_data, got_d;
    logic busy, done, nack, wr_valid, sclk_q, scl_q;
    logic [7:0] mirror [128];                   // Expected register contents
    logic [15:0] mosi_q;                        // Bits seen on MOSI at falls
    int fails = 0, compares = 0, cycles = 0, seed = 32'hd7c1;
    always #5 i_ref_clk = !i_ref_clk;
    codec_link_if link ();
    codec_port_host codec_port_host_inst (.i_ref_clk, .i_rst, .i_ce(1'b1), .i_start(start),
        .i_spi(spi), .i_write(wr), .i_dev_sel(sel), .i_addr(addr), .i_wdata(wdata),
        .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata), .link(link));
    codec_port_device codec_port_device_inst (.i_ref_clk, .i_rst, .i_ce(1'b1), .i_spi_mode(spi),
        .i_addr_strap_low_pin(strap[0]), .i_addr_strap_high_pin(strap[1]), .link(link),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    codec_link_sva codec_link_sva_inst (.i_ref_clk, .i_rst, .h_sda_oe(link.h_sda_oe),
        .h_sclk(link.h_sclk), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
        .d_miso(link.d_miso), .d_miso_oe(link.d_miso_oe), .scl(link.scl), .sclk(link.sclk));
    // Wire monitor, write report capture and hang guard
    always @(posedge i_ref_clk) begin
        {sclk_q, scl_q} <= {link.sclk, link.scl};
        if (scl_q && !link.scl) mosi_q <= 16'h0000;
        else if (sclk_q && !link.sclk) mosi_q <= {mosi_q[14:0], link.sda};
        if (wr_valid === 1'b1) {got_a, got_d} <= {wr_addr, wr_data};
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails = fails + 1;
            finish_test();
        end
    end
    // Command byte as it should appear on the wire
    function automatic logic [7:0] cmd_byte(input logic [6:0] a, input logic rw);
        return {a, rw};
    endfunction : cmd_byte
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One request, then wait for done and a gap for select high
    task automatic xfer(input logic s, w, input logic [1:0] d, input logic [6:0] a,
                        input logic [7:0] v);
        int n;
        @(posedge i_ref_clk);
        {spi, wr, sel, addr, wdata} <= {s, w, d, a, v};
        @(posedge i_ref_clk);
        start <= 1'b1;
        @(posedge i_ref_clk);
        start <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        check("busy", 16'h0001, {15'h0000, busy});
        for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge i_ref_clk);
        #1;
        check("timeout busy", 16'h0000, {14'h0000, n == 5000, busy});
        if (w && (s || d == strap)) mirror[a] = v;
        if (!w) check("read data", {8'h00, mirror[a]}, {8'h00, rdata});
        if (w && (s || d == strap)) check("write report", {1'b0, a, v}, {1'b0, got_a, got_d});
        if (w && s) check("mosi frame", {cmd_byte(a, 1'b0), v}, mosi_q);
        check("nack", {15'h0000, d != strap || s}, {15'h0000, nack ^ s});
        repeat (4) @(posedge i_ref_clk);
    endtask : xfer
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin
        logic [31:0] r;
        for (int i = 0; i < 128; i++) mirror[i] = 8'h00;
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        xfer(1'b1, 1'b0, 2'h0, 7'h7F, 8'h00);
        xfer(1'b0, 1'b1, 2'h0, 7'h00, 8'hA5);
        xfer(1'b0, 1'b1, 2'h3, 7'h01, 8'h5A);
        xfer(1'b1, 1'b1, 2'h0, 7'h7F, 8'hC3);
        xfer(1'b0, 1'b0, 2'h0, 7'h7F, 8'h00);
        $display("test corners done");
        for (int i = 0; i < 14; i++) begin
            r = $random(seed);
            strap <= r[20:19];
            repeat (4) @(posedge i_ref_clk);
            xfer(r[0], r[1], r[20:19], r[8:2], r[16:9]);
        end
        $display("test random done");
        finish_test();
    end
endmodule : codec_control_port_bench
